// ===== rtl/hib_wake_consts.vh
// Constants for the link hibernation and wake-up client block
`ifndef HIB_WAKE_CONSTS_VH
`define HIB_WAKE_CONSTS_VH
// Register indices
`define HW_REG_VSYNC_WAKE 8'h50
`define HW_REG_WAKEPT 8'h51
// Fields of the vsync wake control register
`define HW_WAKE_EN_BIT 0
`define HW_STAT_ACTIVE_BIT 8
`define HW_STAT_WAKE_BIT 9
// Fields of the wake point register
`define HW_FRM_MSB 15
`define HW_FRM_LSB 10
`define HW_LINE_MSB 8
`define HW_LINE_LSB 0
// Reset values
`define HW_WAKE_EN_RST 1'b0
`define HW_WAKEPT_RST 16'h0000
// Strobe cycle counts
`define HW_CNT_DATA_OFF 8'd16
`define HW_CNT_RX_SLEEP 8'd48
`define HW_CNT_SHUTDOWN 8'd64
`define HW_CNT_CLIENT_HI 8'd70
`define HW_CNT_LOW_SEEN 8'd40
// Timing
`define HW_RX_SETUP_NS 200
`define HW_CLK_NS 25
`endif

// ===== rtl/edge_sync.v
// Two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module edge_sync
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Asynchronous level in
    input wire async_i,
    // Synchronised level and edge
    output wire level_o,
    output wire rise_o
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // First flop is read only by the second
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge taken from the settled stages only
    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
endmodule // edge_sync
`default_nettype wire

// ===== rtl/hib_wake_client.v
// Link client hibernation entry, restart and vsync wake point logic
// How it works
// - Receivers may sleep after strobe 48
// - Strobe during hibernation never starts restart
// - Data high on low-power data receiver means wake
// - Hunt sub-frame header after 40 low cycles
// - Strobe offset enabled with receiver for request
// - Drive data high after receiver settles
// - First strobe pulse removes strobe offset
// - Client drives data 70 pulses, then releases
// - Vsync wake enable syncs request to vsync
// - Wake point set by frames and lines
// - Link alive low in hibernation, high after
// - Reaching wake point raises wake request
// - Wake request and enable clear after wake
`timescale 1ns/1ps
`default_nettype none
`include "hib_wake_consts.vh"
module hib_wake_client
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    output reg [15:0] reg_rdata_o,
    // Link pins, received side
    input wire strb_i,
    input wire data_rx_i,
    input wire data_lp_i,
    // Link pins, driven side and receiver control
    output reg data_o,
    output reg data_oe_o,
    output reg strb_rx_en_o,
    output reg strb_offset_en_o,
    output reg data_rx_en_o,
    // Packet and display timing, same clock
    input wire shutdown_crc_i,
    input wire frame_update_i,
    input wire line_pulse_i,
    // Status
    output reg link_active_o,
    output reg client_wakeup_o,
    output reg sfh_search_o
);
    localparam integer SETUP_CYC =
        (`HW_RX_SETUP_NS + `HW_CLK_NS - 1) / `HW_CLK_NS;
    localparam [6:0] ST_ACT = 7'b000_0001;
    localparam [6:0] ST_SHUT = 7'b000_0010;
    localparam [6:0] ST_HIB = 7'b000_0100;
    localparam [6:0] ST_CREQ = 7'b000_1000;
    localparam [6:0] ST_CDRV = 7'b001_0000;
    localparam [6:0] ST_WHI = 7'b010_0000;
    localparam [6:0] ST_WLO = 7'b100_0000;
    wire strb_rise, data_lvl, data_lp_lvl;
    reg [6:0] state_q;
    reg [7:0] cnt_q;
    reg [3:0] setup_q;
    reg wake_done_q;
    reg vsync_wake_enable_q;
    reg [15:0] wakept_q;
    reg [5:0] frm_cnt_q;
    reg [8:0] line_cnt_q;
    reg in_line_q;

    // Pins come from the far side, so all pass two flops
    edge_sync u_strb
    (
        .clk_i(clk_i), .rst_i(rst_i), .async_i(strb_i),
        .level_o(), .rise_o(strb_rise)
    );
    edge_sync u_data
    (
        .clk_i(clk_i), .rst_i(rst_i), .async_i(data_rx_i),
        .level_o(data_lvl), .rise_o()
    );
    edge_sync u_data_lp
    (
        .clk_i(clk_i), .rst_i(rst_i), .async_i(data_lp_i),
        .level_o(data_lp_lvl), .rise_o()
    );

    // Next count and wake point fields, decoded once
    wire [7:0] cnt_inc = cnt_q + 8'd1;
    wire [5:0] wake_frame_count = wakept_q[`HW_FRM_MSB:`HW_FRM_LSB];
    wire [8:0] wake_line_count = wakept_q[`HW_LINE_MSB:`HW_LINE_LSB];
    // Wake point only runs while hibernating and enabled
    wire armed = vsync_wake_enable_q & state_q[2];

    // Link sequencer; strobe edges are counted in the system clock
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_ACT;
            cnt_q <= 8'h00;
            setup_q <= 4'h0;
            wake_done_q <= 1'b0;
            data_o <= 1'b0;
            data_oe_o <= 1'b0;
            strb_rx_en_o <= 1'b1;
            strb_offset_en_o <= 1'b0;
            data_rx_en_o <= 1'b1;
            link_active_o <= 1'b1;
            sfh_search_o <= 1'b0;
        end
        else
        begin
            wake_done_q <= 1'b0;
            sfh_search_o <= 1'b0;
            case (state_q)
                ST_ACT:
                begin
                    if (shutdown_crc_i)
                    begin
                        state_q <= ST_SHUT;
                        cnt_q <= 8'h00;
                    end
                end
                ST_SHUT:
                begin
                    // Host keeps strobing so this count completes
                    if (strb_rise)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc == `HW_CNT_RX_SLEEP)
                            data_rx_en_o <= 1'b0;
                        if (cnt_inc == `HW_CNT_SHUTDOWN)
                        begin
                            state_q <= ST_HIB;
                            strb_rx_en_o <= 1'b0;
                            link_active_o <= 1'b0;
                        end
                    end
                end
                ST_HIB:
                begin
                    // Strobe activity ignored; data level or own wake request wakes
                    if (data_lp_lvl)
                    begin
                        state_q <= ST_WHI;
                        cnt_q <= 8'h00;
                        strb_rx_en_o <= 1'b1;
                        data_rx_en_o <= 1'b1;
                    end
                    else if (client_wakeup_o)
                    begin
                        state_q <= ST_CREQ;
                        setup_q <= 4'h0;
                        strb_offset_en_o <= 1'b1;
                        strb_rx_en_o <= 1'b1;
                    end
                end
                ST_CREQ:
                begin
                    // Receiver gets 200 ns before data goes high
                    if (setup_q != SETUP_CYC[3:0])
                        setup_q <= setup_q + 4'h1;
                    else
                    begin
                        data_oe_o <= 1'b1;
                        data_o <= 1'b1;
                    end
                    if (strb_rise && data_oe_o)
                    begin
                        strb_offset_en_o <= 1'b0;
                        cnt_q <= 8'd1;
                        state_q <= ST_CDRV;
                    end
                end
                ST_CDRV:
                begin
                    if (strb_rise)
                    begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc == `HW_CNT_CLIENT_HI)
                        begin
                            data_oe_o <= 1'b0;
                            data_o <= 1'b0;
                            data_rx_en_o <= 1'b1;
                            state_q <= ST_WHI;
                        end
                    end
                end
                ST_WHI:
                begin
                    // Host high phase ends on first low sample
                    if (strb_rise && !data_lvl)
                    begin
                        cnt_q <= 8'd1;
                        state_q <= ST_WLO;
                    end
                end
                ST_WLO:
                begin
                    if (strb_rise)
                    begin
                        if (data_lvl)
                            state_q <= ST_WHI; // Glitch: restart hunt
                        else if (cnt_inc == `HW_CNT_LOW_SEEN)
                        begin
                            sfh_search_o <= 1'b1;
                            link_active_o <= 1'b1;
                            wake_done_q <= 1'b1;
                            state_q <= ST_ACT;
                        end
                        else
                            cnt_q <= cnt_inc;
                    end
                end
                default:
                    state_q <= ST_ACT;
            endcase
        end
    end

    // Wake point: vsyncs first, then display lines
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frm_cnt_q <= 6'h00;
            line_cnt_q <= 9'h000;
            in_line_q <= 1'b0;
            client_wakeup_o <= 1'b0;
        end
        else if (wake_done_q || !armed)
        begin
            // Request stays up until the link is back
            frm_cnt_q <= 6'h00;
            line_cnt_q <= 9'h000;
            in_line_q <= 1'b0;
            if (wake_done_q)
                client_wakeup_o <= 1'b0;
        end
        else
        begin
            if (frame_update_i && !in_line_q)
            begin
                if (frm_cnt_q == wake_frame_count)
                begin
                    in_line_q <= 1'b1;
                    line_cnt_q <= 9'h000;
                end
                else
                    frm_cnt_q <= frm_cnt_q + 6'h01;
            end
            if (in_line_q && line_cnt_q == wake_line_count)
                client_wakeup_o <= 1'b1;
            else if (in_line_q && line_pulse_i)
                line_cnt_q <= line_cnt_q + 9'h001;
        end
    end

    // Register port; a write beats the auto clear, reads lag one cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            vsync_wake_enable_q <= `HW_WAKE_EN_RST;
            wakept_q <= `HW_WAKEPT_RST;
            reg_rdata_o <= 16'h0000;
        end
        else
        begin
            if (wake_done_q)
                vsync_wake_enable_q <= 1'b0;
            if (reg_wr_i && reg_addr_i == `HW_REG_VSYNC_WAKE)
                vsync_wake_enable_q <= reg_wdata_i[`HW_WAKE_EN_BIT];
            if (reg_wr_i && reg_addr_i == `HW_REG_WAKEPT)
                wakept_q <= reg_wdata_i;
            reg_rdata_o <= 16'h0000; // Unmapped reads zero
            if (reg_addr_i == `HW_REG_VSYNC_WAKE)
            begin
                reg_rdata_o[`HW_WAKE_EN_BIT] <= vsync_wake_enable_q;
                reg_rdata_o[`HW_STAT_ACTIVE_BIT] <= link_active_o;
                reg_rdata_o[`HW_STAT_WAKE_BIT] <= client_wakeup_o;
            end
            if (reg_addr_i == `HW_REG_WAKEPT)
                reg_rdata_o <= wakept_q;
        end
    end
endmodule // hib_wake_client
`default_nettype wire

// ===== dv/hib_wake_checker.sv
// Port assertions for the hibernation and wake-up client
`timescale 1ns/1ps
`default_nettype none
module hib_wake_checker
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched outputs
    input wire logic data_o,
    input wire logic data_oe_o,
    input wire logic strb_rx_en_o,
    input wire logic strb_offset_en_o,
    input wire logic data_rx_en_o,
    input wire logic link_active_o,
    input wire logic client_wakeup_o,
    input wire logic sfh_search_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Exit order: hunt pulse, then request drops
    sequence s_exit;
        sfh_search_o ##1 (!client_wakeup_o && !sfh_search_o);
    endsequence
    exit_order_a: assert property ($rose(link_active_o) |-> s_exit)
        else $error("wake exit order wrong");
    hunt_alive_a: assert property (sfh_search_o |-> link_active_o)
        else $error("hunt pulse while link down");
    sleep_rx_a: assert property ($fell(link_active_o) |->
        !strb_rx_en_o && !data_rx_en_o) else $error("receivers awake");
    offset_rx_a: assert property (strb_offset_en_o |-> strb_rx_en_o)
        else $error("offset without receiver");
    drive_high_a: assert property (data_oe_o |-> data_o)
        else $error("client drives data low");
    rx_settle_a: assert property ($rose(data_oe_o) |->
        $past(strb_offset_en_o, 8)) else $error("data driven too early");
    wake_hold_a: assert property (client_wakeup_o && !link_active_o
        |=> client_wakeup_o) else $error("request dropped early");
    wake_armed_a: assert property ($rose(client_wakeup_o)
        |-> !link_active_o) else $error("request while link up");
    offset_drop_a: assert property ($fell(strb_offset_en_o)
        |-> data_oe_o) else $error("offset dropped too soon");
endmodule // hib_wake_checker
bind hib_wake_client hib_wake_checker u_hib_wake_checker
(
    .clk_i, .rst_i, .data_o, .data_oe_o, .strb_rx_en_o,
    .strb_offset_en_o, .data_rx_en_o, .link_active_o,
    .client_wakeup_o, .sfh_search_o
);
`default_nettype wire

// ===== dv/host_model.sv
// Behavioural link host driving strobe and data
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // Lines seen by the client receivers
    output logic strb_o,
    output logic data_rx_o,
    output logic data_lp_o,
    // Client data driver
    input wire logic cl_oe_i,
    input wire logic cl_d_i
);
    logic h_oe = 1'b0;
    logic h_d = 1'b0;
    logic noise = 1'b0;
    int rises = 0;
    // Undriven pair sits at 0 V, so the fast receiver reads noise
    always #37 noise = ~noise;
    assign data_lp_o = (h_oe & h_d) | (cl_oe_i & cl_d_i);
    assign data_rx_o = h_oe ? h_d : (cl_oe_i ? cl_d_i : noise);
    initial strb_o = 1'b0;
    // Strobe pulses, 200 ns period, still outside them
    task pulses(input int n);
        #7;
        repeat (n)
        begin
            #100 strb_o = 1'b1;
            rises++;
            #100 strb_o = 1'b0;
        end
    endtask
    // Shutdown tail: data low, released at cycle 20, 64 in all
    task shutdown();
        h_oe = 1'b1;
        h_d = 1'b0;
        pulses(20);
        h_oe = 1'b0;
        pulses(44);
    endtask
    // Restart: data high, settle, 150 high, 50 low, then traffic
    task restart();
        h_oe = 1'b1;
        h_d = 1'b1;
        #250;
        rises = 0;
        pulses(150);
        h_d = 1'b0;
        rises = 0;
        pulses(50);
        repeat (6)
        begin
            #200 h_d = ~h_d;
        end
    endtask
    // Answer a client request after a chosen delay
    task serve(input int wait_ns);
        wait (data_lp_o === 1'b1);
        #(wait_ns);
        restart();
    endtask
endmodule // host_model
`default_nettype wire

// ===== dv/hib_wake_client_tb.sv
// Self-checking bench for the hibernation and wake-up client
`timescale 1ns/1ps
`default_nettype none
module hib_wake_client_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic shutdown_crc_i = 1'b0;
    logic frame_update_i = 1'b0;
    logic line_pulse_i = 1'b0;
    logic strb_i, data_rx_i, data_lp_i, data_o, data_oe_o;
    logic strb_rx_en_o, strb_offset_en_o, data_rx_en_o;
    logic link_active_o, client_wakeup_o, sfh_search_o, oe_q;
    logic [15:0] reg_rdata_o;
    int bad_count = 0;
    int tests_run = 0;
    int sfh_n = 0;
    int sfh_at = 0;
    int oe_at = 0;
    initial forever #12.5 clk_i = ~clk_i;
    hib_wake_client u_hib_wake_client
    (
        .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rdata_o, .strb_i, .data_rx_i, .data_lp_i, .data_o,
        .data_oe_o, .strb_rx_en_o, .strb_offset_en_o, .data_rx_en_o,
        .shutdown_crc_i, .frame_update_i, .line_pulse_i,
        .link_active_o, .client_wakeup_o, .sfh_search_o
    );
    host_model u_host_model
    (
        .strb_o(strb_i), .data_rx_o(data_rx_i), .data_lp_o(data_lp_i),
        .cl_oe_i(data_oe_o), .cl_d_i(data_o)
    );
    // Host strobe count when hunting starts and driver lets go
    always @(posedge clk_i)
    begin
        if (sfh_search_o === 1'b1)
        begin
            sfh_n++;
            sfh_at = u_host_model.rises;
        end
        if (oe_q === 1'b1 && data_oe_o === 1'b0)
            oe_at = u_host_model.rises;
        oe_q <= data_oe_o;
    end
    function automatic logic [15:0] pins();
        return {11'h000, link_active_o, strb_rx_en_o, strb_offset_en_o,
            data_oe_o, client_wakeup_o};
    endfunction
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 chk("rdata", e, reg_rdata_o);
    endtask
    // One-cycle pulse: 0 vsync, 1 line, 2 shutdown checksum
    task kick(input int k);
        @(posedge clk_i);
        frame_update_i <= (k == 0);
        line_pulse_i <= (k == 1);
        shutdown_crc_i <= (k == 2);
        @(posedge clk_i);
        {frame_update_i, line_pulse_i, shutdown_crc_i} <= 3'b000;
    endtask
    task hibernate();
        kick(2);
        u_host_model.shutdown();
        repeat (4) @(posedge clk_i);
    endtask
    task t_reset();
        chk("reset pins", 16'h0018, pins());
        rd(8'h50, 16'h0100);
        rd(8'h51, 16'h0000);
        wr(8'h52, 16'hffff);
        rd(8'h52, 16'h0000);
        wr(8'h51, 16'hffff);
        rd(8'h51, 16'hffff);
        wr(8'h50, 16'h0001);
        rd(8'h50, 16'h0101);
        wr(8'h50, 16'h0000);
        $display("t_reset done");
    endtask
    task t_host();
        hibernate();
        chk("sleep pins", 16'h0000, pins());
        chk("fast rx", 16'h0000, {15'h0000, data_rx_en_o});
        u_host_model.pulses(30);
        repeat (4) @(posedge clk_i);
        chk("idle strobe", 16'h0000, pins());
        u_host_model.restart();
        chk("awake pins", 16'h0018, pins());
        chk("fast rx on", 16'h0001, {15'h0000, data_rx_en_o});
        chk("hunts", 16'd1, 16'(sfh_n));
        chk("low count", 16'd40, 16'(sfh_at));
        $display("t_host done");
    endtask
    task t_vsync();
        wr(8'h51, 16'h0402);
        wr(8'h50, 16'h0001);
        hibernate();
        repeat (3) kick(1);
        chk("lines first", 16'h0000, pins());
        kick(0);
        repeat (3) kick(1);
        #1 chk("first frame", 16'h0000, pins());
        kick(0);
        kick(1);
        #1 chk("one line", 16'h0000, pins());
        kick(1);
        repeat (12) @(posedge clk_i);
        #1 chk("request", 16'h000f, pins());
        chk("drive", 16'h0001, {15'h0000, data_o});
        u_host_model.serve(20000);
        chk("released", 16'd70, 16'(oe_at));
        chk("hunt", 16'd40, 16'(sfh_at));
        chk("woken pins", 16'h0018, pins());
        rd(8'h50, 16'h0100);
        $display("t_vsync done");
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence after 4 cycles of reset
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_host();
        t_vsync();
        end_of_test();
    end
    // Watchdog: run needs about 0.14 ms
    initial
    begin
        #1000000;
        bad_count++;
        end_of_test();
    end
endmodule // hib_wake_client_tb
`default_nettype wire
